// ===== logic/pcierp_pkg.sv
/*
 * Types shared by the root port status and capability register bank.
 * Assumes the register header is included by the design file.
 */
package pcierp_pkg;

   // ========================================================================
   // Configuration request carrier
   // ========================================================================
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  dw_addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pcierp_cfg_req_t;

   // Error detection events, one-cycle pulses
   typedef struct packed {
      logic ur;
      logic fatal;
      logic nonfatal;
      logic corr;
   } pcierp_err_t;

endpackage : pcierp_pkg

// ===== logic/pcierp_regs.svh
/*
 * Offsets, field positions, widths and reset values of the root port
 * status and link capability registers.
 * Assumes byte offsets in configuration space, dword access with byte enables.
 */
`ifndef PCIERP_REGS_SVH
`define PCIERP_REGS_SVH

// ==========================================================================
// Offsets
// ==========================================================================
`define PCIERP_DS_OFS          8'h6e
`define PCIERP_LC_OFS          8'h70
`define PCIERP_DS_DW           6'h1b
`define PCIERP_LC_DW           6'h1c

// ==========================================================================
// Device status fields
// ==========================================================================
`define PCIERP_DS_CORR_BIT     0
`define PCIERP_DS_NONFATAL_BIT 1
`define PCIERP_DS_FATAL_BIT    2
`define PCIERP_DS_UR_BIT       3
`define PCIERP_DS_AUX_BIT      4
`define PCIERP_DS_TP_BIT       5
`define PCIERP_DS_LANE_LSB     16
`define PCIERP_DS_RESET        16'h0000

// ==========================================================================
// Link capability fields
// ==========================================================================
`define PCIERP_LC_PORT_LSB     24
`define PCIERP_LC_PORT_NUM     8'h02
`define PCIERP_LC_L1_LSB       15
`define PCIERP_LC_L1_LAT       3'h7
`define PCIERP_LC_L0S_LSB      12
`define PCIERP_LC_L0S_ASYNC    3'h6
`define PCIERP_LC_L0S_COMMON   3'h2
`define PCIERP_LC_ASPM_LSB     10
`define PCIERP_LC_ASPM_L0S     2'h1
`define PCIERP_LC_WIDTH_LSB    4
`define PCIERP_LC_WIDTH_RESET  6'h08
`define PCIERP_LC_SPEED_LSB    0
`define PCIERP_LC_SPEED_RESET  4'h1
`define PCIERP_LC_RESET        32'h0203e481

`endif

// ===== logic/pcierp_status_caps.sv
/*
 * Root port device status and link capability registers.
 * Assumes a configuration access agent that issues one dword request per
 * cycle with byte enables, a transaction layer reporting pending work and
 * error pulses, and a link control block giving the common clock bit.
 */
//
// Function
// - Pending bit high while transactions outstanding
// - Pending bit clears only when all finished
// - Unsupported request sets its sticky bit
// - Fatal error sets its sticky bit
// - Nonfatal error sets its sticky bit
// - Correctable error sets its sticky bit
// - Error bits hold; write one clears
// - Auxiliary power bit always reads zero
// - Port number reads two in top byte
// - L1 exit latency reads over 64 us
// - L0s latency follows common clock bit
// - Power support field reads L0s only
// - Link width defaults x8, write once
// - Link speed defaults 2.5G, write once
`timescale 1ns/1ps
`include "pcierp_regs.svh"

module pcierp_status_caps (
   input  wire logic                       sys_clk_i,
   input  wire logic                       reset_i,
   input  wire pcierp_pkg::pcierp_cfg_req_t cfg_req_i,
   input  wire logic                       txn_pending_i,
   input  wire pcierp_pkg::pcierp_err_t    err_detect_i,
   input  wire logic                       common_clock_cfg_i,
   output logic [31:0]                     cfg_rdata_o,
   output logic                            cfg_rvalid_o,
   output logic [15:0]                     dev_status_o
);

   // =======================================================================
   // Decode
   // =======================================================================
   logic        hit_ds;
   logic        hit_lc;
   logic        ds_clr_ok;
   logic        lc_wr;

   // Status lives in the upper half of the dword shared with device control
   always_comb begin
      hit_ds = 1'b0;
      hit_lc = 1'b0;
      if (cfg_req_i.dw_addr == `PCIERP_DS_DW) begin
         hit_ds = 1'b1;
      end else if (cfg_req_i.dw_addr == `PCIERP_LC_DW) begin
         hit_lc = 1'b1;
      end
   end

   assign ds_clr_ok = cfg_req_i.wr & hit_ds & cfg_req_i.be[2];
   assign lc_wr     = cfg_req_i.wr & hit_lc & (cfg_req_i.be[1:0] != 2'b00);

   // =======================================================================
   // Device status
   // =======================================================================
   logic       tp_r;
   logic       tp_nxt;
   logic [3:0] err_r;
   logic [3:0] err_nxt;
   logic [3:0] err_clr;

   // Set beats clear so an error landing on the clear write is kept
   always_comb begin
      tp_nxt  = txn_pending_i;
      err_clr = ds_clr_ok ? cfg_req_i.wdata[`PCIERP_DS_LANE_LSB +: 4] : 4'h0;
      err_nxt = (err_r & ~err_clr)
              | {err_detect_i.ur, err_detect_i.fatal,
                 err_detect_i.nonfatal, err_detect_i.corr};
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tp_r  <= 1'b0;
         err_r <= 4'h0;
      end else begin
         tp_r  <= tp_nxt;
         err_r <= err_nxt;
      end
   end

   // Aux power and bits 15:6 are constant zero
   logic [15:0] ds_val;
   always_comb begin
      ds_val = `PCIERP_DS_RESET;
      ds_val[`PCIERP_DS_TP_BIT]        = tp_r;
      ds_val[`PCIERP_DS_UR_BIT]        = err_r[3];
      ds_val[`PCIERP_DS_FATAL_BIT]     = err_r[2];
      ds_val[`PCIERP_DS_NONFATAL_BIT]  = err_r[1];
      ds_val[`PCIERP_DS_CORR_BIT]      = err_r[0];
   end

   // =======================================================================
   // Link capabilities, write-once width and speed
   // =======================================================================
   logic       wo_lock_r;
   logic       wo_lock_nxt;
   logic [5:0] width_r;
   logic [5:0] width_nxt;
   logic [3:0] speed_r;
   logic [3:0] speed_nxt;

   // One lock covers both fields: firmware sets them in a single write
   always_comb begin
      wo_lock_nxt = wo_lock_r;
      width_nxt   = width_r;
      speed_nxt   = speed_r;
      if (lc_wr && !wo_lock_r) begin
         wo_lock_nxt = 1'b1;
         if (cfg_req_i.be[0]) begin
            speed_nxt      = cfg_req_i.wdata[3:0];
            width_nxt[3:0] = cfg_req_i.wdata[7:4];
         end
         if (cfg_req_i.be[1]) begin
            width_nxt[5:4] = cfg_req_i.wdata[9:8];
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wo_lock_r <= 1'b0;
         width_r   <= `PCIERP_LC_WIDTH_RESET;
         speed_r   <= `PCIERP_LC_SPEED_RESET;
      end else begin
         wo_lock_r <= wo_lock_nxt;
         width_r   <= width_nxt;
         speed_r   <= speed_nxt;
      end
   end

   // Latency re-encodes live; a retrain is software's business
   logic [31:0] lc_val;
   always_comb begin
      lc_val = 32'h0000_0000;
      lc_val[`PCIERP_LC_PORT_LSB +: 8]  = `PCIERP_LC_PORT_NUM;
      lc_val[`PCIERP_LC_L1_LSB +: 3]    = `PCIERP_LC_L1_LAT;
      lc_val[`PCIERP_LC_L0S_LSB +: 3]   = common_clock_cfg_i ?
                                          `PCIERP_LC_L0S_COMMON : `PCIERP_LC_L0S_ASYNC;
      lc_val[`PCIERP_LC_ASPM_LSB +: 2]  = `PCIERP_LC_ASPM_L0S;
      lc_val[`PCIERP_LC_WIDTH_LSB +: 6] = width_r;
      lc_val[`PCIERP_LC_SPEED_LSB +: 4] = speed_r;
   end

   // =======================================================================
   // Read return, one cycle after the request
   // =======================================================================
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        rvalid_r;
   logic        rvalid_nxt;
   logic [15:0] ds_out_r;

   // Unmapped dwords read zero; device control half not held here
   always_comb begin
      rvalid_nxt = cfg_req_i.rd;
      rdata_nxt  = rdata_r;
      if (cfg_req_i.rd) begin
         if (hit_ds) begin
            rdata_nxt = {ds_val, 16'h0000};
         end else if (hit_lc) begin
            rdata_nxt = lc_val;
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
         ds_out_r <= `PCIERP_DS_RESET;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         ds_out_r <= ds_val;
      end
   end

   assign cfg_rdata_o  = rdata_r;
   assign cfg_rvalid_o = rvalid_r;
   assign dev_status_o = ds_out_r;

   // =======================================================================
   // Assertions
   // =======================================================================
   property p_tp_follow;
      @(posedge sys_clk_i) disable iff (reset_i)
      txn_pending_i |=> ##1 dev_status_o[`PCIERP_DS_TP_BIT];
   endproperty
   a_tp_follow: assert property (p_tp_follow) else $error("pending bit not set");

   property p_tp_clear;
      @(posedge sys_clk_i) disable iff (reset_i)
      $fell(tp_r) |-> !$past(txn_pending_i);
   endproperty
   a_tp_clear: assert property (p_tp_clear) else $error("pending cleared early");

   property p_ur_set;
      @(posedge sys_clk_i) disable iff (reset_i)
      err_detect_i.ur |=> ##1 dev_status_o[`PCIERP_DS_UR_BIT];
   endproperty
   a_ur_set: assert property (p_ur_set) else $error("ur bit not set");

   property p_fatal_set;
      @(posedge sys_clk_i) disable iff (reset_i)
      err_detect_i.fatal |=> err_r[2];
   endproperty
   a_fatal_set: assert property (p_fatal_set) else $error("fatal bit not set");

   property p_nonfatal_set;
      @(posedge sys_clk_i) disable iff (reset_i)
      err_detect_i.nonfatal |=> err_r[1];
   endproperty
   a_nonfatal_set: assert property (p_nonfatal_set) else $error("nonfatal bit not set");

   property p_corr_set;
      @(posedge sys_clk_i) disable iff (reset_i)
      err_detect_i.corr |=> err_r[0];
   endproperty
   a_corr_set: assert property (p_corr_set) else $error("corr bit not set");

   property p_sticky;
      @(posedge sys_clk_i) disable iff (reset_i)
      (err_r[0] && !(ds_clr_ok && cfg_req_i.wdata[`PCIERP_DS_LANE_LSB])) |=> err_r[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("error bit lost");

   property p_aux_zero;
      @(posedge sys_clk_i) disable iff (reset_i)
      (cfg_req_i.rd && hit_ds) |=> (cfg_rdata_o[31:22] == 10'h000) && !cfg_rdata_o[20];
   endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("reserved status bits set");

   property p_lc_fixed;
      @(posedge sys_clk_i) disable iff (reset_i)
      (cfg_req_i.rd && hit_lc) |=> (cfg_rdata_o[31:24] == `PCIERP_LC_PORT_NUM)
         && (cfg_rdata_o[23:15] == 9'h007) && (cfg_rdata_o[11:10] == `PCIERP_LC_ASPM_L0S);
   endproperty
   a_lc_fixed: assert property (p_lc_fixed) else $error("fixed capability wrong");

   property p_l0s;
      @(posedge sys_clk_i) disable iff (reset_i)
      (cfg_req_i.rd && hit_lc) |=> (cfg_rdata_o[14:12] ==
         ($past(common_clock_cfg_i) ? `PCIERP_LC_L0S_COMMON : `PCIERP_LC_L0S_ASYNC));
   endproperty
   a_l0s: assert property (p_l0s) else $error("l0s latency wrong");

   property p_wo_hold;
      @(posedge sys_clk_i) disable iff (reset_i)
      wo_lock_r |=> $stable(width_r) && $stable(speed_r);
   endproperty
   a_wo_hold: assert property (p_wo_hold) else $error("write-once field changed");

   c_err_clear: cover property (@(posedge sys_clk_i) disable iff (reset_i) err_r[3] ##1 !err_r[3]);
   c_wo_write:  cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(wo_lock_r));
   c_set_clr:   cover property (@(posedge sys_clk_i) disable iff (reset_i) ds_clr_ok && err_detect_i.corr);
   c_tp_cycle:  cover property (@(posedge sys_clk_i) disable iff (reset_i) tp_r ##[1:20] !tp_r);

endmodule : pcierp_status_caps

// ===== verif/pcierp_status_caps_tb.sv
/*
 * Self-checking bench for the root port status and link capability bank.
 * Assumes the design's own checks are bound in its files; the bench plays
 * the configuration agent, the transaction layer and link control.
 */
`timescale 1ns/1ps

module pcierp_status_caps_tb;

   // =======================================================================
   // Stimulus and observation
   // =======================================================================
   logic                        sys_clk;
   logic                        reset;
   pcierp_pkg::pcierp_cfg_req_t req;
   logic                        pend;
   pcierp_pkg::pcierp_err_t     err;
   logic                        cclk;
   logic [31:0]                 rdata;
   logic                        rvalid;
   logic [15:0]                 dsts;
   int                          failures;
   int                          checks;

   pcierp_status_caps uut (
      .sys_clk_i          (sys_clk),
      .reset_i            (reset),
      .cfg_req_i          (req),
      .txn_pending_i      (pend),
      .err_detect_i       (err),
      .common_clock_cfg_i (cclk),
      .cfg_rdata_o        (rdata),
      .cfg_rvalid_o       (rvalid),
      .dev_status_o       (dsts)
   );

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // =======================================================================
   // Compare tasks
   // =======================================================================
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk16

   // =======================================================================
   // Access tasks
   // =======================================================================
   // Settle 1 ns past the edge so registered outputs have landed
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // Read answers on the edge that takes the request, valid for one cycle only
   task automatic cfg_rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      req <= '{rd: 1'b1, wr: 1'b0, dw_addr: a, be: 4'h0, wdata: 32'h0000_0000};
      @(posedge sys_clk);
      req <= '0;
      #1;
      chk32({31'h0000_0000, rvalid}, 32'h0000_0001);
      chk32(rdata, exp);
   endtask : cfg_rd

   task automatic cfg_wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{rd: 1'b0, wr: 1'b1, dw_addr: a, be: be, wdata: d};
      @(posedge sys_clk);
      req <= '0;
   endtask : cfg_wr

   // Single-cycle error event on one of the four detectors
   task automatic pulse(input int k);
      @(posedge sys_clk);
      err <= pcierp_pkg::pcierp_err_t'(4'h1 << k);
      @(posedge sys_clk);
      err <= '0;
   endtask : pulse

   task automatic conclude;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // =======================================================================
   // Watchdog: the sequence needs about 115 cycles
   // =======================================================================
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      conclude();
   end

   // =======================================================================
   // Main sequence
   // =======================================================================
   initial begin
      failures = 0;
      checks = 0;
      reset = 1'b1;
      req = '0;
      pend = 1'b0;
      err = '0;
      cclk = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      tick(1);
      chk16(dsts, 16'h0000);
      // Reset image of both registers and an unmapped place
      cfg_rd(6'h1c, 32'h0203_e481);
      cfg_rd(6'h1b, 32'h0000_0000);
      cfg_rd(6'h00, 32'h0000_0000);
      // L0s latency follows the common clock bit both ways
      @(posedge sys_clk);
      cclk <= 1'b1;
      cfg_rd(6'h1c, 32'h0203_a481);
      @(posedge sys_clk);
      cclk <= 1'b0;
      cfg_rd(6'h1c, 32'h0203_e481);
      // Each sticky error: set, survive zero and wrong-lane writes, clear
      for (int k = 0; k < 4; k++) begin
         pulse(k);
         tick(1);
         chk16(dsts, 16'h0001 << k);
         cfg_rd(6'h1b, 32'h0001_0000 << k);
         cfg_wr(6'h1b, 4'hf, 32'h0000_0000);
         cfg_wr(6'h1b, 4'hb, 32'hffff_ffff);
         tick(2);
         chk16(dsts, 16'h0001 << k);
         cfg_wr(6'h1b, 4'h4, 32'h0001_0000 << k);
         cfg_rd(6'h1b, 32'h0000_0000);
      end
      // Error landing on its own clear write must survive
      @(posedge sys_clk);
      err <= pcierp_pkg::pcierp_err_t'(4'h1);
      req <= '{rd: 1'b0, wr: 1'b1, dw_addr: 6'h1b, be: 4'h4, wdata: 32'h0001_0000};
      @(posedge sys_clk);
      err <= '0;
      req <= '0;
      tick(1);
      chk16(dsts, 16'h0001);
      cfg_wr(6'h1b, 4'h4, 32'h0001_0000);
      cfg_rd(6'h1b, 32'h0000_0000);
      // Pending level is hardware owned; aux and reserved bits stay zero
      @(posedge sys_clk);
      pend <= 1'b1;
      tick(2);
      chk16(dsts, 16'h0020);
      cfg_wr(6'h1b, 4'hf, 32'hffff_ffe0);
      cfg_rd(6'h1b, 32'h0020_0000);
      @(posedge sys_clk);
      pend <= 1'b0;
      tick(2);
      chk16(dsts, 16'h0000);
      // Write-once width and speed, read-only fields untouched
      cfg_wr(6'h1c, 4'hf, 32'hffff_fc42);
      cfg_rd(6'h1c, 32'h0203_e442);
      cfg_wr(6'h1c, 4'h3, 32'h0000_03ff);
      cfg_rd(6'h1c, 32'h0203_e442);
      cfg_wr(6'h3f, 4'hf, 32'hffff_ffff);
      cfg_rd(6'h3f, 32'h0000_0000);
      // Mid-run reset restores defaults and re-arms the write-once lock
      @(posedge sys_clk);
      reset <= 1'b1;
      tick(2);
      chk16(dsts, 16'h0000);
      @(posedge sys_clk);
      reset <= 1'b0;
      cfg_rd(6'h1c, 32'h0203_e481);
      cfg_wr(6'h1c, 4'h1, 32'h0000_0042);
      cfg_rd(6'h1c, 32'h0203_e442);
      conclude();
   end

endmodule : pcierp_status_caps_tb
